// [rtl/fetch_exec_map.svh]
/*
 * Constants of the fetch/execute core: widths, reset values, data address
 * split points and the core register addresses in the data space.
 * Assumes inclusion by data_addr_map and fetch_execute_core; definitions only.
 */
`ifndef FETCH_EXEC_MAP_SVH
`define FETCH_EXEC_MAP_SVH

// Widths
`define FE_PC_W 21
`define FE_DADDR_W 12
`define FE_IWORD_W 16

// Program counter
`define FE_PC_RESET 21'h000000
`define FE_PC_STEP 21'h000002

// Second word of a two-word instruction carries this top nibble
`define FE_TWO_WORD_TAG 4'hF

// Access Bank split and the banks it reaches
`define FE_ACCESS_SPLIT 8'h60
`define FE_ACCESS_LOW_BANK 4'h0
`define FE_ACCESS_HIGH_BANK 4'hF

// Core registers that live in the data space
`define FE_SFR_WORKING 12'hFE0
`define FE_SFR_BANK_PTR 12'hFE1
`define FE_SFR_PC_LOW 12'hFE2
`define FE_SFR_TBL_PTR_L 12'hFE3
`define FE_SFR_TBL_PTR_H 12'hFE4
`define FE_SFR_TBL_PTR_U 12'hFE5
`define FE_SFR_TBL_LATCH 12'hFE6
`define FE_SFR_FSR_BASE 12'hFD0

// Number of file select registers
`define FE_FSR_COUNT 3

`endif

// [rtl/fetch_exec_pkg.sv]
/*
 * Types of the fetch/execute core: quarter phases and decoded operations.
 * Assumes the opcode layout of the core's 16-bit instruction words.
 */
package fetch_exec_pkg;

	typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;

	typedef enum logic [3:0] {
		OP_NOP, OP_GOTO, OP_CALL, OP_MOVE_FF, OP_LOAD_FSR, OP_BRA,
		OP_ADD_WF, OP_RET_LIT, OP_MOV_LIT, OP_MOV_LB, OP_TEST_SKIP, OP_TBL_READ
	} op_t;

	// Tagged second words and unknown codes all decode as no-operation
	function automatic op_t decode_op(input logic [15:0] w);
		op_t op;
		op = OP_NOP;
		casez (w)
			16'hEF??: op = OP_GOTO;
			16'hEC??, 16'hED??: op = OP_CALL;
			16'hC???: op = OP_MOVE_FF;
			16'hEE0?, 16'hEE1?, 16'hEE2?: op = OP_LOAD_FSR;
			16'hD0??, 16'hD1??, 16'hD2??, 16'hD3??: op = OP_BRA;
			16'hD4??, 16'hD5??, 16'hD6??, 16'hD7??: op = OP_BRA;
			16'h24??, 16'h25??, 16'h26??, 16'h27??: op = OP_ADD_WF;
			16'h0C??: op = OP_RET_LIT;
			16'h0E??: op = OP_MOV_LIT;
			16'h010?: op = OP_MOV_LB;
			16'h66??, 16'h67??: op = OP_TEST_SKIP;
			16'h0008: op = OP_TBL_READ;
			default: op = OP_NOP;
		endcase
		return op;
	endfunction

endpackage

// [rtl/quarter_phase_gen.sv]
/*
 * Quarter phase generator: splits the core clock into four one-cycle
 * phase enables that repeat as one instruction cycle.
 * Assumes a single free-running clock and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module quarter_phase_gen
	import fetch_exec_pkg::*;
(
	// Clock and reset
	input logic clk_i,
	input logic resetn_i,
	// Phase enables
	output logic q1_o,
	output logic q2_o,
	output logic q3_o,
	output logic q4_o
);

	phase_t phase_q;

	// Divide by four; reset restarts at the first phase
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			phase_q <= PH_Q1;
		end else begin
			unique case (phase_q)
				PH_Q1: phase_q <= PH_Q2;
				PH_Q2: phase_q <= PH_Q3;
				PH_Q3: phase_q <= PH_Q4;
				PH_Q4: phase_q <= PH_Q1;
			endcase
		end
	end

	// Non-overlapping one-hot phase enables
	assign q1_o = (phase_q == PH_Q1);
	assign q2_o = (phase_q == PH_Q2);
	assign q3_o = (phase_q == PH_Q3);
	assign q4_o = (phase_q == PH_Q4);

endmodule // quarter_phase_gen

// [rtl/data_addr_map.sv]
/*
 * Data address former: joins the bank pointer and an 8-bit offset, or maps
 * the offset through the Access Bank when the access bit is clear.
 * Assumes the offset and bit come straight from the instruction word.
 */
`timescale 1ns/100ps
`include "fetch_exec_map.svh"
module data_addr_map
	import fetch_exec_pkg::*;
(
	// Instruction fields
	input logic banked_i,
	input logic [7:0] offset_i,
	// Bank pointer nibble
	input logic [3:0] bank_i,
	// Full 12-bit data address
	output logic [11:0] addr_o
);

	// Access Bank: low offsets go to bank 0, the rest to the top bank
	always_comb begin
		if (banked_i) begin
			addr_o = {bank_i, offset_i};
		end else if (offset_i < `FE_ACCESS_SPLIT) begin
			addr_o = {`FE_ACCESS_LOW_BANK, offset_i};
		end else begin
			addr_o = {`FE_ACCESS_HIGH_BANK, offset_i};
		end
	end

endmodule // data_addr_map

// [rtl/fetch_execute_core.sv]
/*
 * Fetch/execute sequencer of the 8-bit core: quarter phases, two-stage
 * pipeline with flush, two-word instructions, computed jumps, table reads
 * and banked data addressing with core registers in the data space.
 * Assumes program memory answers a word within the same instruction cycle
 * (address stable from Q2, word read in Q3/Q4) and data memory answers a
 * read within Q2; dmem_present_i marks implemented data locations.
 */
// Notes on behaviour
// - clock divided by four into four non-overlapping quarter phases.
// - PC advances each first phase; fetched word captured in fourth phase.
// - fetched word latched in first phase, executed over phases two to four.
// - data operand read in phase two, destination written in phase four.
// - next word fetched while current executes; one instruction per cycle.
// - PC-changing instructions take two cycles; fetched word is flushed.
// - program memory byte addressed; instruction words start at even addresses.
// - PC steps by two and its lowest bit is always zero.
// - absolute call and jump load word address into PC bits 20 to 1.
// - relative branch offsets count single words, not bytes.
// - call, file move, jump, file-select load use an extra word.
// - second words carry 1111 on top and twelve literal bits.
// - a lone 1111 word executes as no-operation.
// - adding working register to PC low byte makes a computed jump.
// - table reads fetch one byte at the table pointer into the latch.
// - data address is 12 bits: sixteen banks of 256 bytes.
// - reads of unimplemented data locations return zero.
// - Access Bank reaches bank 0 low and top SFRs without bank pointer.
// - Access offsets below 60h go to bank 0, others to bank 15.
// - bank pointer keeps four low bits; upper bits read zero.
`timescale 1ns/100ps
`include "fetch_exec_map.svh"
module fetch_execute_core
	import fetch_exec_pkg::*;
(
	// Clock and reset
	input logic clk_i,
	input logic resetn_i,
	// Program memory
	output logic [20:0] pmem_addr_o,
	input logic [15:0] pmem_rdata_i,
	// Data memory
	output logic [11:0] dmem_addr_o,
	output logic dmem_rd_o,
	input logic [7:0] dmem_rdata_i,
	input logic dmem_present_i,
	output logic dmem_wr_o,
	output logic [7:0] dmem_wdata_o,
	// Phase and state view
	output logic q1_o,
	output logic q4_o,
	output logic [20:0] pc_o,
	output logic [15:0] instruction_latch_o,
	output logic exec_valid_o,
	output logic [7:0] working_register_o,
	output logic [7:0] table_latch_o
);

	logic q1;
	logic q2;
	logic q3;
	logic q4;
	logic [20:0] pc_q;
	logic [20:0] fetch_addr_q;
	logic [20:0] pmem_addr_q;
	logic [15:0] prefetch_q;
	logic prefetch_valid_q;
	logic [15:0] instruction_latch_q;
	logic exec_valid_q;
	op_t op_q;
	op_t next_op;
	logic [11:0] addr_q;
	logic [11:0] mapped_addr;
	logic [7:0] operand_q;
	logic [7:0] result_q;
	logic wr_en_q;
	logic [7:0] working_register_q;
	logic [3:0] bank_pointer_q;
	logic [20:0] table_pointer_q;
	logic [7:0] table_latch_q;
	logic [20:0] return_addr_q;
	logic [11:0] fsr_q [`FE_FSR_COUNT];
	logic core_hit;
	logic [7:0] core_rdata;
	logic core_wr;
	logic pc_load;
	logic [20:0] pc_target;
	logic kill_next;

	quarter_phase_gen u_phase (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.q1_o(q1),
		.q2_o(q2),
		.q3_o(q3),
		.q4_o(q4)
	);

	// Address of the operand of the word about to enter execute
	data_addr_map u_dmap (
		.banked_i(prefetch_q[8]),
		.offset_i(prefetch_q[7:0]),
		.bank_i(bank_pointer_q),
		.addr_o(mapped_addr)
	);

	assign next_op = prefetch_valid_q ? decode_op(prefetch_q) : OP_NOP;

	// Program counter: steps by two each Q1, reloaded at Q4 on a jump
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pc_q <= `FE_PC_RESET;
			fetch_addr_q <= `FE_PC_RESET;
		end else if (q1) begin
			fetch_addr_q <= pc_q;
			pc_q <= pc_q + `FE_PC_STEP;
		end else if (q4 && pc_load) begin
			pc_q <= {pc_target[20:1], 1'b0};
		end
	end

	// Program memory address; a table read borrows the fetch slot
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pmem_addr_q <= `FE_PC_RESET;
		end else if (q1) begin
			if (next_op == OP_TBL_READ) begin
				pmem_addr_q <= {table_pointer_q[20:1], 1'b0};
			end else begin
				pmem_addr_q <= pc_q;
			end
		end
	end

	// Prefetch capture at Q4; flushed when the PC jumps or a word is consumed
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			prefetch_q <= 16'h0000;
			prefetch_valid_q <= 1'b0;
		end else if (q4) begin
			prefetch_q <= pmem_rdata_i;
			prefetch_valid_q <= !(pc_load || kill_next);
		end
	end

	// Execute stage entry at Q1: overlaps with the next fetch
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			instruction_latch_q <= 16'h0000;
			exec_valid_q <= 1'b0;
			op_q <= OP_NOP;
		end else if (q1) begin
			instruction_latch_q <= prefetch_q;
			exec_valid_q <= prefetch_valid_q;
			op_q <= next_op;
		end
	end

	// Data address: full 12 bits for the file move source, else banked/access;
	// the move destination is taken from the second word during Q3
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			addr_q <= 12'h000;
		end else if (q1) begin
			if (next_op == OP_MOVE_FF) begin
				addr_q <= prefetch_q[11:0];
			end else begin
				addr_q <= mapped_addr;
			end
		end else if (q3 && op_q == OP_MOVE_FF) begin
			addr_q <= pmem_rdata_i[11:0];
		end
	end

	// Core registers that answer inside the data space
	always_comb begin
		core_hit = 1'b1;
		core_rdata = 8'h00;
		case (addr_q)
			`FE_SFR_WORKING: core_rdata = working_register_q;
			`FE_SFR_BANK_PTR: core_rdata = {4'h0, bank_pointer_q};
			`FE_SFR_PC_LOW: core_rdata = fetch_addr_q[7:0];
			`FE_SFR_TBL_PTR_L: core_rdata = table_pointer_q[7:0];
			`FE_SFR_TBL_PTR_H: core_rdata = table_pointer_q[15:8];
			`FE_SFR_TBL_PTR_U: core_rdata = {3'h0, table_pointer_q[20:16]};
			`FE_SFR_TBL_LATCH: core_rdata = table_latch_q;
			default: core_hit = 1'b0;
		endcase
		for (int i = 0; i < `FE_FSR_COUNT; i++) begin
			if (addr_q == `FE_SFR_FSR_BASE + 12'(2 * i)) begin
				core_hit = 1'b1;
				core_rdata = fsr_q[i][7:0];
			end
			if (addr_q == `FE_SFR_FSR_BASE + 12'(2 * i + 1)) begin
				core_hit = 1'b1;
				core_rdata = {4'h0, fsr_q[i][11:8]};
			end
		end
	end

	// Operand read strobe in Q2
	assign dmem_rd_o = q2 && !core_hit &&
		(op_q == OP_ADD_WF || op_q == OP_TEST_SKIP || op_q == OP_MOVE_FF);

	// Operand capture at Q2; absent locations read as zero
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			operand_q <= 8'h00;
		end else if (q2) begin
			if (core_hit) begin
				operand_q <= core_rdata;
			end else if (dmem_present_i) begin
				operand_q <= dmem_rdata_i;
			end else begin
				operand_q <= 8'h00;
			end
		end
	end

	// Result formed in Q3, write enable cleared at the next Q1
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			result_q <= 8'h00;
			wr_en_q <= 1'b0;
		end else if (q1) begin
			wr_en_q <= 1'b0;
		end else if (q3) begin
			if (op_q == OP_ADD_WF) begin
				result_q <= operand_q + working_register_q;
				wr_en_q <= instruction_latch_q[9];
			end else if (op_q == OP_MOVE_FF) begin
				result_q <= operand_q;
				wr_en_q <= 1'b1;
			end
		end
	end

	// Destination write in Q4; core registers never reach the memory bus
	assign core_wr = q4 && wr_en_q && core_hit;
	assign dmem_wr_o = q4 && wr_en_q && !core_hit;
	assign dmem_addr_o = addr_q;
	assign dmem_wdata_o = result_q;

	// Flow control decided in Q4 of the execute cycle
	always_comb begin
		pc_load = 1'b0;
		pc_target = pc_q;
		kill_next = 1'b0;
		if (exec_valid_q) begin
			case (op_q)
				OP_GOTO, OP_CALL: begin
					// Second word arrives in this same cycle's fetch slot
					pc_load = 1'b1;
					pc_target = {pmem_rdata_i[11:0], instruction_latch_q[7:0], 1'b0};
				end
				OP_MOVE_FF, OP_LOAD_FSR: kill_next = 1'b1;
				OP_BRA: begin
					pc_load = 1'b1;
					pc_target = fetch_addr_q +
						{{9{instruction_latch_q[10]}}, instruction_latch_q[10:0], 1'b0};
				end
				OP_RET_LIT: begin
					pc_load = 1'b1;
					pc_target = return_addr_q;
				end
				OP_TBL_READ: begin
					// Refetch the word whose slot the table read used
					pc_load = 1'b1;
					pc_target = fetch_addr_q;
				end
				OP_TEST_SKIP: kill_next = (operand_q == 8'h00);
				default: kill_next = 1'b0;
			endcase
			if (core_wr && addr_q == `FE_SFR_PC_LOW) begin
				// Low bit forced clear; even offsets expected of software
				pc_load = 1'b1;
				pc_target = {fetch_addr_q[20:8], result_q[7:1], 1'b0};
			end
		end
	end

	// Working register: literal loads, add result, or data-space write
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			working_register_q <= 8'h00;
		end else if (q4 && exec_valid_q) begin
			if (op_q == OP_MOV_LIT || op_q == OP_RET_LIT) begin
				working_register_q <= instruction_latch_q[7:0];
			end else if (op_q == OP_ADD_WF && !instruction_latch_q[9]) begin
				working_register_q <= result_q;
			end else if (core_wr && addr_q == `FE_SFR_WORKING) begin
				working_register_q <= result_q;
			end
		end
	end

	// Bank pointer holds only four bits; upper written bits are dropped
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			bank_pointer_q <= 4'h0;
		end else if (q4 && exec_valid_q) begin
			if (op_q == OP_MOV_LB) begin
				bank_pointer_q <= instruction_latch_q[3:0];
			end else if (core_wr && addr_q == `FE_SFR_BANK_PTR) begin
				bank_pointer_q <= result_q[3:0];
			end
		end
	end

	// Table pointer bytes written through the data space
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			table_pointer_q <= 21'h000000;
		end else if (core_wr) begin
			if (addr_q == `FE_SFR_TBL_PTR_L) begin
				table_pointer_q[7:0] <= result_q;
			end else if (addr_q == `FE_SFR_TBL_PTR_H) begin
				table_pointer_q[15:8] <= result_q;
			end else if (addr_q == `FE_SFR_TBL_PTR_U) begin
				table_pointer_q[20:16] <= result_q[4:0];
			end
		end
	end

	// Table latch: one byte per read, odd address takes the high byte
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			table_latch_q <= 8'h00;
		end else if (q4 && exec_valid_q && op_q == OP_TBL_READ) begin
			table_latch_q <= table_pointer_q[0] ? pmem_rdata_i[15:8] : pmem_rdata_i[7:0];
		end else if (core_wr && addr_q == `FE_SFR_TBL_LATCH) begin
			table_latch_q <= result_q;
		end
	end

	// Single return address; a nested call overwrites it
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			return_addr_q <= `FE_PC_RESET;
		end else if (q4 && exec_valid_q && op_q == OP_CALL) begin
			return_addr_q <= pc_q;
		end
	end

	// File select loads: 12-bit literal split over both words
	for (genvar g = 0; g < `FE_FSR_COUNT; g++) begin : g_fsr
		always_ff @(posedge clk_i or negedge resetn_i) begin
			if (!resetn_i) begin
				fsr_q[g] <= 12'h000;
			end else if (q4 && exec_valid_q && op_q == OP_LOAD_FSR &&
					instruction_latch_q[5:4] == 2'(g)) begin
				fsr_q[g] <= {instruction_latch_q[3:0], pmem_rdata_i[7:0]};
			end
		end
	end

	// View outputs, all from flip-flops apart from the phase enables
	assign q1_o = q1;
	assign q4_o = q4;
	assign pmem_addr_o = pmem_addr_q;
	assign pc_o = pc_q;
	assign instruction_latch_o = instruction_latch_q;
	assign exec_valid_o = exec_valid_q;
	assign working_register_o = working_register_q;
	assign table_latch_o = table_latch_q;

endmodule // fetch_execute_core

// [verif/fetch_execute_core_props.sv]
/*
 * Checker of the fetch/execute core: phase, pipeline flush and strobe timing.
 * Assumes binding to fetch_execute_core, one clock domain, active-low reset.
 */
`timescale 1ns/100ps
module fetch_execute_core_props (
	// Clock and reset
	input logic clk_i,
	input logic resetn_i,
	// Watched outputs
	input logic [20:0] pmem_addr_o,
	input logic dmem_rd_o,
	input logic dmem_wr_o,
	input logic q1_o,
	input logic q4_o,
	input logic [20:0] pc_o,
	input logic [15:0] instruction_latch_o,
	input logic exec_valid_o
);
	// Low through the first edge after release, while the core still sits in reset;
	// without it the phase checks would start one edge early and fire on a clean run
	logic run_q;
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			run_q <= 1'b0;
		end else begin
			run_q <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i || !run_q);
	// An instruction cycle is exactly four clocks long
	sequence s_gap;
		!q1_o [*3] ##1 q1_o;
	endsequence
	// A flushed slot lasts exactly one instruction cycle
	sequence s_bubble;
		!exec_valid_o [*4] ##1 exec_valid_o;
	endsequence
	property p_q_cycle;
		q1_o |=> s_gap;
	endproperty
	a_q_cycle: assert property (p_q_cycle) else $error("phase period wrong");
	property p_q_order;
		q1_o |-> !q4_o ##3 q4_o;
	endproperty
	a_q_order: assert property (p_q_order) else $error("phase order wrong");
	// Steps happen at the end of Q1, jump loads at the end of Q4
	property p_pc_q1;
		!$stable(pc_o) |-> $past(q1_o) || $past(q4_o);
	endproperty
	a_pc_q1: assert property (p_pc_q1) else $error("pc moved off phase one");
	property p_fetch_q1;
		!$stable(pmem_addr_o) |-> $past(q1_o);
	endproperty
	a_fetch_q1: assert property (p_fetch_q1) else $error("fetch address moved");
	property p_pc_even;
		pc_o[0] == 1'b0 && pmem_addr_o[0] == 1'b0;
	endproperty
	a_pc_even: assert property (p_pc_even) else $error("odd program address");
	property p_latch_q1;
		!$stable({instruction_latch_o, exec_valid_o}) |-> $past(q1_o);
	endproperty
	a_latch_q1: assert property (p_latch_q1) else $error("latch moved off phase one");
	property p_rd_q2;
		dmem_rd_o |-> $past(q1_o) && !q1_o && !q4_o;
	endproperty
	a_rd_q2: assert property (p_rd_q2) else $error("read outside phase two");
	property p_wr_q4;
		dmem_wr_o |-> q4_o && !dmem_rd_o ##1 !dmem_wr_o;
	endproperty
	a_wr_q4: assert property (p_wr_q4) else $error("write outside phase four");
	property p_flush;
		$fell(exec_valid_o) |-> s_bubble;
	endproperty
	a_flush: assert property (p_flush) else $error("flush length wrong");
endmodule // fetch_execute_core_props

bind fetch_execute_core fetch_execute_core_props i_props (
	.clk_i(clk_i),
	.resetn_i(resetn_i),
	.pmem_addr_o(pmem_addr_o),
	.dmem_rd_o(dmem_rd_o),
	.dmem_wr_o(dmem_wr_o),
	.q1_o(q1_o),
	.q4_o(q4_o),
	.pc_o(pc_o),
	.instruction_latch_o(instruction_latch_o),
	.exec_valid_o(exec_valid_o)
);

// [verif/fe_mem_model.sv]
/*
 * Far-side model: program memory words and byte-wide banked data memory.
 * Assumes the bench preloads both arrays while the core is held in reset.
 */
`timescale 1ns/100ps
module fe_mem_model (
	// Clock and phase
	input logic clk_i,
	input logic q1_i,
	input logic slow_i,
	// Program memory
	input logic [20:0] pmem_addr_i,
	output logic [15:0] pmem_rdata_o,
	// Data memory
	input logic [11:0] dmem_addr_i,
	input logic dmem_rd_i,
	output logic [7:0] dmem_rdata_o,
	output logic dmem_present_o,
	input logic dmem_wr_i,
	input logic [7:0] dmem_wdata_i
);
	logic [15:0] pmem [0:255];
	logic [7:0] dmem [0:4095];
	logic [15:0] word;
	// Byte bit dropped; only the low 256 words exist, so fetches wrap
	assign word = pmem[pmem_addr_i[8:1]];
	// Slow mode shows garbage in phase one, since the word is owed only from phase two
	assign pmem_rdata_o = (slow_i && q1_i) ? ~word : word;
	// Bank 13 is left out so that a dead read shows up as junk
	assign dmem_present_o = dmem_addr_i[11:8] != 4'hD;
	assign dmem_rdata_o = (dmem_rd_i && dmem_present_o) ? dmem[dmem_addr_i] : ~dmem[dmem_addr_i];
	// Writes land only in implemented banks
	always @(posedge clk_i) begin
		if (dmem_wr_i && dmem_present_o) begin
			dmem[dmem_addr_i] <= dmem_wdata_i;
		end
	end
endmodule // fe_mem_model

// [verif/cpu_fetch_execute_pipeline_tb.sv]
/*
 * Bench of the fetch/execute core: runs a small program twice, the second
 * time with a slow program memory and a reset while the core is looping.
 * Assumes fe_mem_model as the far side; data writes are the observed results.
 */
`timescale 1ns/100ps
module cpu_fetch_execute_pipeline_tb;
	logic clk_i, resetn_i, slow, dmem_rd, dmem_present, dmem_wr, q1, q4, ev;
	logic [20:0] pmem_addr, pc;
	logic [15:0] pmem_rdata, il;
	logic [11:0] dmem_addr;
	logic [7:0] dmem_rdata, dmem_wdata, working_register, tlat;
	logic [7:0] rv [8];
	logic [19:0] exp_q [$];
	int fails = 0;
	int n_checks = 0;
	int k;
	// Index and word; gaps hold a data write that executes only at index 1, after the literal load
	// Call into a computed return table, file select load read back by a file move
	localparam logic [23:0] PROG [27] = '{24'h020101, 24'h032720, 24'h042670,
		24'h05010D, 24'h062500, 24'h072611, 24'h086612, 24'h09C012, 24'h0AF013,
		24'h0BC011, 24'h0CF014, 24'h0DEF20, 24'h0EF000, 24'h20D003, 24'h240E81,
		24'h2526E3, 24'h260008, 24'h270E04, 24'h28EC30, 24'h29F000, 24'h2A2615,
		24'h2BEE13, 24'h2CF05C, 24'h2DCFD2, 24'h2EF016, 24'h2FD7FF, 24'h3026E2};

	fetch_execute_core i_dut (.clk_i(clk_i), .resetn_i(resetn_i), .pmem_addr_o(pmem_addr),
		.pmem_rdata_i(pmem_rdata), .dmem_addr_o(dmem_addr), .dmem_rd_o(dmem_rd),
		.dmem_rdata_i(dmem_rdata), .dmem_present_i(dmem_present), .dmem_wr_o(dmem_wr),
		.dmem_wdata_o(dmem_wdata), .q1_o(q1), .q4_o(q4), .pc_o(pc),
		.instruction_latch_o(il), .exec_valid_o(ev), .working_register_o(working_register),
		.table_latch_o(tlat));
	fe_mem_model i_mem (.clk_i(clk_i), .q1_i(q1), .slow_i(slow), .pmem_addr_i(pmem_addr),
		.pmem_rdata_o(pmem_rdata), .dmem_addr_i(dmem_addr), .dmem_rd_i(dmem_rd),
		.dmem_rdata_o(dmem_rdata), .dmem_present_o(dmem_present), .dmem_wr_i(dmem_wr),
		.dmem_wdata_i(dmem_wdata));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		if (fails == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// 40 MHz clock
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	// Every data write must match the oldest note; a stray one means a leaked flush
	always @(negedge clk_i) begin
		if (resetn_i && dmem_wr === 1'b1) begin
			if (exp_q.size() == 0) check(32'h0, 32'h1);
			else check({dmem_addr, dmem_wdata}, exp_q.pop_front());
		end
	end

	// Two passes; the second resets the core in mid-run
	initial begin
		resetn_i = 1'b0;
		slow = 1'b0;
		void'($urandom(39242));
		for (int pass = 0; pass < 2; pass++) begin
			@(posedge clk_i);
			resetn_i <= 1'b0;
			for (int i = 0; i < 8; i++) rv[i] = 8'($urandom);
			for (int i = 0; i < 256; i++) i_mem.pmem[i] = 16'h2610;
			foreach (PROG[i]) i_mem.pmem[PROG[i][23:16]] = PROG[i][15:0];
			i_mem.pmem[0] = {8'h0E, rv[0]};
			i_mem.pmem[64] = {rv[6], 8'h5A};
			// Table entry the computed jump must land on; its neighbours are stray writes
			i_mem.pmem[51] = {8'h0C, rv[7]};
			i_mem.dmem[12'h010] = rv[1];
			i_mem.dmem[12'h120] = rv[2];
			i_mem.dmem[12'hF70] = rv[3];
			i_mem.dmem[12'h011] = rv[4];
			i_mem.dmem[12'h012] = 8'h00;
			i_mem.dmem[12'h015] = rv[5];
			// Offset 4 keeps the computed jump on a word boundary
			exp_q = '{{12'h010, rv[0] + rv[1]}, {12'h120, rv[0] + rv[2]},
				{12'hF70, rv[0] + rv[3]}, {12'h011, rv[0] + rv[4]},
				{12'h014, rv[0] + rv[4]}, {12'h015, rv[7] + rv[5]},
				{12'h016, 8'h5C}};
			repeat (5) @(posedge clk_i);
			check({pc, ev, q1}, {21'h0, 1'b0, 1'b1});
			resetn_i <= 1'b1;
			slow <= pass[0];
			for (k = 0; k < 600 && exp_q.size() > 0; k++) @(posedge clk_i);
			if (exp_q.size() > 0) begin
				fails++;
				summarize();
			end
			// Let the core settle into its closing branch loop, then catch an executing slot
			repeat (16) @(posedge clk_i);
			@(negedge clk_i);
			if (!ev) repeat (4) @(negedge clk_i);
			check(tlat, rv[6]);
			check(working_register, rv[7]);
			check({ev, il}, {1'b1, 16'hD7FF});
		end
		summarize();
	end
endmodule // cpu_fetch_execute_pipeline_tb
